// ### aiom_datapath.sv
// Execution datapath: OR with literal or file register, increment, moves.
// Assumes cmd_valid/cmd are synchronous to mclk and one operation completes per cycle.
`timescale 1ns/10ps
`default_nettype none

module aiom_datapath (
  input  wire logic               mclk,
  input  wire logic               rst_b,
  input  wire logic               cmd_valid,
  input  wire aiom_pkg::aiom_cmd_t cmd,
  output var  aiom_pkg::aiom_result_t res
);

  logic       rst_s1_b_reg;
  logic       rst_b_reg;
  logic [7:0] acc_reg;
  logic       zero_reg;
  logic       file_we_reg;
  logic [6:0] file_addr_reg;
  logic [7:0] file_data_reg;
  logic [7:0] file_mem [aiom_pkg::FILE_DEPTH];

  // Reset is applied at once but released through two flops, so every reset
  // register below leaves reset on the same clean edge of mclk; the file array has none
  always_ff @(posedge mclk or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_b_reg <= 1'b0;
      rst_b_reg    <= 1'b0;
    end else begin
      rst_s1_b_reg <= 1'b1;
      rst_b_reg    <= rst_s1_b_reg;
    end
  end

  // Operand selection and result
  wire aiom_pkg::aiom_op_t op = cmd_valid ? cmd.op : aiom_pkg::AIOM_NOP;
  wire logic [7:0] file_rd    = file_mem[cmd.faddr];
  wire logic       is_orl     = (op == aiom_pkg::AIOM_OR_LITERAL_INTO_ACC);
  wire logic       is_inc     = (op == aiom_pkg::AIOM_INCREMENT_REGISTER);
  wire logic       is_orf     = (op == aiom_pkg::AIOM_OR_ACC_WITH_REGISTER);
  wire logic       is_mov     = (op == aiom_pkg::AIOM_MOVE_REGISTER);
  wire logic       is_st      = (op == aiom_pkg::AIOM_STORE_ACC_TO_REGISTER);
  wire logic       is_ldl     = (op == aiom_pkg::AIOM_LOAD_LITERAL_TO_ACC);
  wire logic       uses_dest  = is_inc | is_orf | is_mov;
  wire logic [7:0] alu_out    = is_orl ? (acc_reg | cmd.literal) :
                                is_inc ? 8'(file_rd + aiom_pkg::ONE_BYTE) :
                                is_orf ? (acc_reg | file_rd) :
                                is_ldl ? cmd.literal :
                                is_st  ? acc_reg :
                                file_rd;
  wire logic       to_file    = is_st | (uses_dest & (cmd.dest == aiom_pkg::DEST_FILE));
  wire logic       to_acc     = is_orl | is_ldl |
                                (uses_dest & (cmd.dest == aiom_pkg::DEST_ACC));
  wire logic       z_upd      = is_orl | uses_dest;
  wire logic [7:0] acc_next   = to_acc ? alu_out : acc_reg;
  wire logic       zero_next  = z_upd ? (alu_out == 8'h00) : zero_reg;

  always_ff @(posedge mclk or negedge rst_b_reg) begin
    if (!rst_b_reg) begin
      acc_reg       <= aiom_pkg::ACC_RESET;
      zero_reg      <= aiom_pkg::ZERO_RESET;
      file_we_reg   <= 1'b0;
      file_addr_reg <= 7'h00;
      file_data_reg <= aiom_pkg::FILE_RESET;
    end else begin
      acc_reg       <= acc_next;
      zero_reg      <= zero_next;
      file_we_reg   <= to_file;
      file_addr_reg <= cmd.faddr;
      file_data_reg <= alu_out;
    end
  end

  // File array has no reset: software initialises it, as with real data RAM
  always_ff @(posedge mclk) begin
    if (to_file) begin
      file_mem[cmd.faddr] <= alu_out;
    end
  end

  assign res.acc       = acc_reg;
  assign res.zero      = zero_reg;
  assign res.file_we   = file_we_reg;
  assign res.file_addr = file_addr_reg;
  assign res.file_data = file_data_reg;

  // Checks
  property p_orl;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_orl |=> (acc_reg == ($past(acc_reg) | $past(cmd.literal))) &&
               (zero_reg == (acc_reg == 8'h00));
  endproperty
  a_orl: assert property (p_orl) else $error("or-literal result wrong");

  property p_inc;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_inc |=> file_data_reg == 8'($past(file_rd) + 8'h01);
  endproperty
  a_inc: assert property (p_inc) else $error("increment result wrong");

  property p_dest;
    @(posedge mclk) disable iff (!rst_b_reg)
    uses_dest |=> file_we_reg == $past(cmd.dest);
  endproperty
  a_dest: assert property (p_dest) else $error("destination routing wrong");

  property p_dest_acc;
    @(posedge mclk) disable iff (!rst_b_reg)
    (uses_dest && cmd.dest) |=> $stable(acc_reg);
  endproperty
  a_dest_acc: assert property (p_dest_acc) else $error("acc changed on file dest");

  property p_orf;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_orf |=> file_data_reg == ($past(acc_reg) | $past(file_rd));
  endproperty
  a_orf: assert property (p_orf) else $error("or-register result wrong");

  property p_mov;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_mov |=> zero_reg == ($past(file_rd) == 8'h00);
  endproperty
  a_mov: assert property (p_mov) else $error("move zero test wrong");

  property p_st;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_st |=> $stable(zero_reg) && file_we_reg && (file_data_reg == $past(acc_reg));
  endproperty
  a_st: assert property (p_st) else $error("store changed flag or data");

  property p_ldl;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_ldl |=> $stable(zero_reg) && (acc_reg == $past(cmd.literal));
  endproperty
  a_ldl: assert property (p_ldl) else $error("load-literal wrong");

  property p_zero;
    @(posedge mclk) disable iff (!rst_b_reg)
    z_upd |=> zero_reg == (file_data_reg == 8'h00);
  endproperty
  a_zero: assert property (p_zero) else $error("zero flag mismatch");

  // Routing checks: each result reaches the selected destination and leaves the other side alone
  property p_inc_acc;
    @(posedge mclk) disable iff (!rst_b_reg)
    (is_inc && !cmd.dest) |=> acc_reg == 8'($past(file_rd) + 8'h01);
  endproperty
  a_inc_acc: assert property (p_inc_acc) else $error("increment to acc wrong");

  property p_dest_file_off;
    @(posedge mclk) disable iff (!rst_b_reg)
    (uses_dest && !cmd.dest) |=> !file_we_reg;
  endproperty
  a_dest_file_off: assert property (p_dest_file_off) else $error("file written on acc dest");

  property p_we_addr;
    @(posedge mclk) disable iff (!rst_b_reg)
    to_file |=> file_we_reg && (file_addr_reg == $past(cmd.faddr));
  endproperty
  a_we_addr: assert property (p_we_addr) else $error("write address wrong");

  property p_orf_acc;
    @(posedge mclk) disable iff (!rst_b_reg)
    (is_orf && !cmd.dest) |=> acc_reg == ($past(acc_reg) | $past(file_rd));
  endproperty
  a_orf_acc: assert property (p_orf_acc) else $error("or-register to acc wrong");

  property p_mov_acc;
    @(posedge mclk) disable iff (!rst_b_reg)
    (is_mov && !cmd.dest) |=> acc_reg == $past(file_rd);
  endproperty
  a_mov_acc: assert property (p_mov_acc) else $error("move to acc wrong");

  property p_mov_keep;
    @(posedge mclk) disable iff (!rst_b_reg)
    (is_mov && cmd.dest) |=> file_data_reg == $past(file_rd);
  endproperty
  a_mov_keep: assert property (p_mov_keep) else $error("zero test altered register");

  property p_st_acc;
    @(posedge mclk) disable iff (!rst_b_reg)
    is_st |=> $stable(acc_reg);
  endproperty
  a_st_acc: assert property (p_st_acc) else $error("store changed acc");

  // Flag must hold through every operation that does not own it, idle included
  property p_flag_hold;
    @(posedge mclk) disable iff (!rst_b_reg)
    !z_upd |=> $stable(zero_reg);
  endproperty
  a_flag_hold: assert property (p_flag_hold) else $error("zero flag moved");

  property p_idle;
    @(posedge mclk) disable iff (!rst_b_reg)
    !cmd_valid |=> !file_we_reg && $stable(acc_reg) && $stable(zero_reg);
  endproperty
  a_idle: assert property (p_idle) else $error("state changed while idle");

  property p_zero_set;
    @(posedge mclk) disable iff (!rst_b_reg)
    (to_acc && z_upd) |=> zero_reg == (acc_reg == 8'h00);
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag not set on clear");

  c_store: cover property (@(posedge mclk) disable iff (!rst_b_reg)
    is_st);
  c_orf_file: cover property (@(posedge mclk) disable iff (!rst_b_reg)
    is_orf && cmd.dest);
  c_inc_wrap: cover property (@(posedge mclk) disable iff (!rst_b_reg)
    is_inc && file_rd == 8'hFF);
  c_mov_test: cover property (@(posedge mclk) disable iff (!rst_b_reg)
    is_mov && cmd.dest);
  c_orl_zero: cover property (@(posedge mclk) disable iff (!rst_b_reg)
    is_orl ##1 zero_reg);

endmodule // aiom_datapath

`default_nettype wire

// ### aiom_pkg.sv
// Package for the accumulator OR / increment / move execution datapath.
// Assumes a fetch/decode stage outside that hands over one decoded operation per cycle.
package aiom_pkg;

  localparam int unsigned DATA_W    = 8;
  localparam int unsigned ADDR_W    = 7;
  localparam int unsigned FILE_DEPTH = 128;

  localparam logic [7:0] ACC_RESET  = 8'h00;
  localparam logic [7:0] FILE_RESET = 8'h00;
  localparam logic       ZERO_RESET = 1'b0;
  localparam logic [7:0] ONE_BYTE   = 8'h01;

  // Destination-select bit values
  localparam logic DEST_ACC  = 1'b0;
  localparam logic DEST_FILE = 1'b1;

  typedef enum logic [2:0] {
    AIOM_NOP,
    AIOM_OR_LITERAL_INTO_ACC,
    AIOM_INCREMENT_REGISTER,
    AIOM_OR_ACC_WITH_REGISTER,
    AIOM_MOVE_REGISTER,
    AIOM_STORE_ACC_TO_REGISTER,
    AIOM_LOAD_LITERAL_TO_ACC
  } aiom_op_t;

  typedef struct packed {
    aiom_op_t   op;
    logic [6:0] faddr;
    logic       dest;
    logic [7:0] literal;
  } aiom_cmd_t;

  typedef struct packed {
    logic [7:0] acc;
    logic       zero;
    logic       file_we;
    logic [6:0] file_addr;
    logic [7:0] file_data;
  } aiom_result_t;

endpackage

// ### tb.sv
// Self-checking bench for the OR / increment / move execution datapath.
// Assumes one-cycle latency from a taken command to res, and a two-flop reset release.
`timescale 1ns/10ps
`default_nettype none

module tb;
  localparam aiom_pkg::aiom_op_t NP = aiom_pkg::AIOM_NOP;
  localparam aiom_pkg::aiom_op_t OL = aiom_pkg::AIOM_OR_LITERAL_INTO_ACC;
  localparam aiom_pkg::aiom_op_t IN = aiom_pkg::AIOM_INCREMENT_REGISTER;
  localparam aiom_pkg::aiom_op_t OR = aiom_pkg::AIOM_OR_ACC_WITH_REGISTER;
  localparam aiom_pkg::aiom_op_t MV = aiom_pkg::AIOM_MOVE_REGISTER;
  localparam aiom_pkg::aiom_op_t ST = aiom_pkg::AIOM_STORE_ACC_TO_REGISTER;
  localparam aiom_pkg::aiom_op_t LL = aiom_pkg::AIOM_LOAD_LITERAL_TO_ACC;

  logic                   mclk;
  logic                   rst_b;
  logic                   cmd_valid;
  aiom_pkg::aiom_cmd_t    cmd;
  aiom_pkg::aiom_result_t res;
  int                     n_fail;
  int                     tests_run;

  aiom_datapath i_aiom_datapath (
    .mclk      (mclk),
    .rst_b     (rst_b),
    .cmd_valid (cmd_valid),
    .cmd       (cmd),
    .res       (res)
  );

  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic close_out();
    if (n_fail == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Drives one command across an edge; file_data is not checked after load, nop or idle
  task automatic run(input logic v, input aiom_pkg::aiom_op_t o, input logic [6:0] a,
                     input logic d, input logic [7:0] l, input logic [7:0] ea,
                     input logic ez, input logic ew, input logic [7:0] ed);
    cmd_valid = v;
    cmd = '{op: o, faddr: a, dest: d, literal: l};
    @(posedge mclk);
    #10;
    chk({res.acc, res.zero, res.file_we}, {ea, ez, ew});
    if (ew)
      chk({3'h0, res.file_addr}, {3'h0, a});
    if (v && o != NP && o != LL)
      chk({2'h0, res.file_data}, {2'h0, ed});
  endtask

  task automatic t_load_store();
    run(1'b1, LL, 7'h00, 1'b1, 8'h5A, 8'h5A, 1'b0, 1'b0, 8'h00);
    run(1'b1, ST, 7'h7F, 1'b0, 8'hFF, 8'h5A, 1'b0, 1'b1, 8'h5A);
    run(1'b1, LL, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
    run(1'b1, ST, 7'h00, 1'b1, 8'h00, 8'h00, 1'b0, 1'b1, 8'h00);
  endtask

  task automatic t_move();
    run(1'b1, MV, 7'h7F, 1'b0, 8'h00, 8'h5A, 1'b0, 1'b0, 8'h5A);
    run(1'b1, MV, 7'h00, 1'b1, 8'h00, 8'h5A, 1'b1, 1'b1, 8'h00);
    run(1'b1, MV, 7'h7F, 1'b1, 8'h00, 8'h5A, 1'b0, 1'b1, 8'h5A);
  endtask

  // Wrap to zero then read back the written value on the very next cycle
  task automatic t_inc();
    run(1'b1, LL, 7'h00, 1'b0, 8'hFF, 8'hFF, 1'b0, 1'b0, 8'h00);
    run(1'b1, ST, 7'h10, 1'b0, 8'h00, 8'hFF, 1'b0, 1'b1, 8'hFF);
    run(1'b1, IN, 7'h10, 1'b1, 8'h00, 8'hFF, 1'b1, 1'b1, 8'h00);
    run(1'b1, IN, 7'h10, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0, 8'h01);
    run(1'b0, IN, 7'h10, 1'b1, 8'h00, 8'h01, 1'b0, 1'b0, 8'h00);
  endtask

  task automatic t_or();
    run(1'b1, OL, 7'h00, 1'b0, 8'h00, 8'h01, 1'b0, 1'b0, 8'h01);
    run(1'b1, LL, 7'h00, 1'b0, 8'h00, 8'h00, 1'b0, 1'b0, 8'h00);
    run(1'b1, OL, 7'h00, 1'b0, 8'h00, 8'h00, 1'b1, 1'b0, 8'h00);
    run(1'b1, LL, 7'h00, 1'b0, 8'h30, 8'h30, 1'b1, 1'b0, 8'h00);
    run(1'b1, ST, 7'h20, 1'b0, 8'h00, 8'h30, 1'b1, 1'b1, 8'h30);
    run(1'b1, LL, 7'h00, 1'b0, 8'h05, 8'h05, 1'b1, 1'b0, 8'h00);
    run(1'b1, OR, 7'h20, 1'b1, 8'h00, 8'h05, 1'b0, 1'b1, 8'h35);
    run(1'b1, OR, 7'h20, 1'b0, 8'h00, 8'h35, 1'b0, 1'b0, 8'h35);
    run(1'b1, OL, 7'h00, 1'b1, 8'h80, 8'hB5, 1'b0, 1'b0, 8'hB5);
    run(1'b1, NP, 7'h20, 1'b1, 8'h00, 8'hB5, 1'b0, 1'b0, 8'h00);
    run(1'b0, NP, 7'h00, 1'b0, 8'h00, 8'hB5, 1'b0, 1'b0, 8'h00);
  endtask

  initial begin
    n_fail = 0;
    tests_run = 0;
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd = '0;
    repeat (3) @(posedge mclk);
    #10;
    rst_b = 1'b1;
    repeat (3) @(posedge mclk);
    #10;
    chk({res.acc, res.zero, res.file_we}, {8'h00, 1'b0, 1'b0});
    t_load_store();
    t_move();
    t_inc();
    t_or();
    close_out();
  end

  // Whole run is about 29 cycles; this margin only catches a hang
  initial begin
    #100000;
    n_fail++;
    close_out();
  end
endmodule // tb

`default_nettype wire
